// ### common/sram_page_select_cfg.svh
// Constants of the SRAM page select block: register indices, bit positions,
// reset values and bus encodings.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SRAM_PAGE_SELECT_CFG_SVH
`define SRAM_PAGE_SELECT_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SPS_CUR_IDX        10'h0d0
`define SPS_SCRATCH_IDX    10'h060
`define SPS_FLAG_IDX       10'h0f7
`define SPS_SCRATCH_CNT    4
`define SPS_SCRATCH_SEL_W  2

// ****************************************************************
// Address and field positions
// ****************************************************************
`define SPS_IDX_MSB        11
`define SPS_IDX_LSB        2
`define SPS_MODE_HI        7
`define SPS_MODE_LO        6
`define SPS_BYTE_MSB       7

// ****************************************************************
// Reset values and bus encodings
// ****************************************************************
`define SPS_REG_RST        8'h00
`define SPS_HSIZE_WORD     3'h2
`define SPS_HTRANS_ACT     1
`define SPS_HRESP_OKAY     1'b0

`endif

// ### common/sram_page_select_pkg.sv
// Types shared by the SRAM page select block.
// Assumes the constants header is on the include path.
`include "sram_page_select_cfg.svh"

package sram_page_select_pkg;

  // Kind of data memory access presented by the core
  typedef enum logic [2:0] {
    NORMAL_ACCESS,
    STACK_ACCESS,
    INDEXED_ACCESS,
    MOVE_POINTER_ACCESS,
    MOVE_READ_ACCESS,
    MOVE_WRITE_ACCESS
  } access_kind_type;

endpackage

// ### rtl/page_mux.sv
// Combinational page choice for one data memory access.
// Assumes pointers already narrowed to the page bits by the caller.
module page_mux
  import sram_page_select_pkg::*;
#(
  parameter int PAGE_W = 1
) (
  input  wire logic [1:0]        pageMode,
  input  access_kind_type        accessKind,
  input  wire logic              regSpace,
  input  wire logic [PAGE_W-1:0] curPage,
  input  wire logic [PAGE_W-1:0] stackPage,
  input  wire logic [PAGE_W-1:0] indexPage,
  input  wire logic [PAGE_W-1:0] moveReadPage,
  input  wire logic [PAGE_W-1:0] moveWritePage,
  output logic      [PAGE_W-1:0] page
);

  // ****************************************************************
  // Page per access class
  // ****************************************************************

  // Normal and move-pointer accesses follow the upper mode bit only
  wire logic [PAGE_W-1:0] normalPage;
  assign normalPage = pageMode[1] ? curPage : '0;

  // Indexed SRAM: low mode bit picks the stack page, else index or page 0
  wire logic [PAGE_W-1:0] indexedPage;
  assign indexedPage = regSpace    ? '0 :
                       pageMode[0] ? stackPage :
                       pageMode[1] ? indexPage : '0;

  // Final selection by access kind; mode bits never touch stack or move data
  always_comb begin
    case (accessKind)
      STACK_ACCESS:        page = stackPage;
      INDEXED_ACCESS:      page = indexedPage;
      MOVE_READ_ACCESS:    page = moveReadPage;
      MOVE_WRITE_ACCESS:   page = moveWritePage;
      default:             page = normalPage;
    endcase
  end

endmodule

// ### rtl/sram_page_select.sv
// SRAM page select for an 8-bit core with paged data memory, with the
// flag register page-mode handling and an AHB-Lite register slave.
// Assumes one clock, a single AHB-Lite master doing word transfers, and a
// core that stacks the pushed flag byte and pops it back on return.
//
// Function
// - Upper mode bit set steers normal accesses to the current page pointer.
// - Upper mode bit clear sends normal accesses to page 0.
// - Interrupt entry pushes the flag byte, then clears it to mode 00b.
// - Interrupt return restores the pushed flag byte, including mode bits.
// - Reset leaves mode 00b; indexed and normal accesses go to page 0.
// - Modes 01b and 11b send indexed SRAM accesses to the stack page.
// - Mode 10b sends indexed SRAM accesses to the index page.
// - Indexed register-space accesses are never remapped.
// - Current page pointer never affects indexed or stack accesses.
// - Move pointer byte follows the normal rule: current page with upper mode bit set, else page 0.
// - Current page pointer is read/write, resets to zero, page bit at 0.
// - Four 8-bit read/write scratch registers reset to zero.
// - Scratch registers reachable whatever bank is selected.
// - Supervisory calls run in mode 00b and restore the flag after.
// - Stack operations always use the stack page pointer.
// - Move data accesses use the move read or move write page pointer.
// - Flag bit 7 is the upper page-mode bit.
`include "sram_page_select_cfg.svh"

module sram_page_select
  import sram_page_select_pkg::*;
#(
  parameter int PAGE_W = 1
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Access request from the core
  input  wire logic        accessValid,
  input  access_kind_type  accessKind,
  input  wire logic        regSpaceAccess,
  // Page pointers kept elsewhere
  input  wire logic [7:0]  stackPagePointer,
  input  wire logic [7:0]  indexPagePointer,
  input  wire logic [7:0]  moveReadPagePointer,
  input  wire logic [7:0]  moveWritePagePointer,
  // Flag register events from the core
  input  wire logic        flagWrite,
  input  wire logic [7:0]  flagWriteData,
  input  wire logic        interruptEntry,
  input  wire logic        interruptReturn,
  input  wire logic [7:0]  popFlagData,
  input  wire logic        supervisoryCall,
  input  wire logic        supervisoryReturn,
  output logic [7:0]       flagValue,
  output logic [7:0]       pushFlagData,
  output logic             pushFlagValid,
  // Page answer, one cycle after the request
  output logic             pageValid,
  output logic [PAGE_W-1:0] sramPage,
  output logic             regSpaceOut
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]        flag_q;
  logic [7:0]        savedFlag_q;
  logic [7:0]        pushFlag_q;
  logic              pushValid_q;
  logic [PAGE_W-1:0] curPage_q;
  logic [7:0]        scratch_q [`SPS_SCRATCH_CNT];
  logic              wrPend_q;
  logic [9:0]        wrIdx_q;
  logic [31:0]       hrdata_q;
  logic              pageValid_q;
  logic [PAGE_W-1:0] sramPage_q;
  logic              regSpace_q;

  // Scratch block base as a named vector, so its upper bits can be sliced
  localparam logic [9:0] scratchBase = `SPS_SCRATCH_IDX;

  // ****************************************************************
  // Bus address decode
  // ****************************************************************

  // Only aligned word transfers with a clean upper address count as mapped
  wire logic       addrPhase;
  wire logic [9:0] addrIdx;
  wire logic       addrClean;
  assign addrPhase = hsel && htrans[`SPS_HTRANS_ACT] && hready;
  assign addrIdx   = haddr[`SPS_IDX_MSB:`SPS_IDX_LSB];
  assign addrClean = (haddr[31:`SPS_IDX_MSB+1] == '0) && (haddr[1:0] == '0)
                     && (hsize == `SPS_HSIZE_WORD);

  // Write commits in the data phase, when hwdata is on the bus
  wire logic       wrCommit;
  wire logic       wrCur;
  wire logic       wrFlag;
  wire logic       wrScratch;
  wire logic [1:0] wrSel;
  assign wrCommit  = wrPend_q && hready;
  assign wrCur     = wrCommit && (wrIdx_q == `SPS_CUR_IDX);
  assign wrFlag    = wrCommit && (wrIdx_q == `SPS_FLAG_IDX);
  assign wrScratch = wrCommit &&
    (wrIdx_q[9:`SPS_SCRATCH_SEL_W] == scratchBase[9:`SPS_SCRATCH_SEL_W]);
  assign wrSel     = wrIdx_q[`SPS_SCRATCH_SEL_W-1:0];

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Unmapped addresses read zero unless read right behind a write to them; upper pointer bits read zero
  wire logic [7:0] curRead;
  wire logic [7:0] rdValue;
  wire logic       rdScratch;
  assign curRead   = {{(8-PAGE_W){1'b0}}, curPage_q};
  assign rdScratch =
    (addrIdx[9:`SPS_SCRATCH_SEL_W] == scratchBase[9:`SPS_SCRATCH_SEL_W]);
  assign rdValue   = !addrClean                   ? `SPS_REG_RST :
                     (addrIdx == `SPS_CUR_IDX)    ? curRead :
                     (addrIdx == `SPS_FLAG_IDX)   ? flag_q :
                     rdScratch ? scratch_q[addrIdx[`SPS_SCRATCH_SEL_W-1:0]] :
                     `SPS_REG_RST;

  // A read right behind a write to the same word sees the new value
  wire logic       rdForward;
  wire logic [7:0] wrStored;
  wire logic [7:0] rdNext;
  assign rdForward = wrCommit && addrClean && (wrIdx_q == addrIdx);
  assign wrStored  = (wrIdx_q == `SPS_CUR_IDX) ?
                     {{(8-PAGE_W){1'b0}}, hwdata[PAGE_W-1:0]} : hwdata[7:0];
  assign rdNext    = rdForward ? wrStored : rdValue;

  // Bus handshake: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `SPS_HRESP_OKAY;
  assign hrdata    = hrdata_q;

  // Address phase capture and read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= '0;
      hrdata_q <= '0;
    end else begin
      if (hready) begin
        wrPend_q <= addrPhase && hwrite && addrClean;
        wrIdx_q  <= addrIdx;
      end
      if (addrPhase && !hwrite) begin
        hrdata_q <= {24'h0, rdNext};
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************

  // Only the page bits are stored; reserved bits are left to software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      curPage_q <= '0;
    end else if (wrCur) begin
      curPage_q <= hwdata[PAGE_W-1:0];
    end
  end

  // Scratch words, decoded by index alone so no bank select gates them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SPS_SCRATCH_CNT; i++) begin
        scratch_q[i] <= `SPS_REG_RST;
      end
    end else if (wrScratch) begin
      scratch_q[wrSel] <= hwdata[`SPS_BYTE_MSB:0];
    end
  end

  // ****************************************************************
  // Flag register
  // ****************************************************************

  // Entry events win over returns, returns over plain writes; the stacked
  // copy is the only record, so a lost pop cannot be recovered here
  wire logic       flagClear;
  wire logic [7:0] flag_d;
  assign flagClear = interruptEntry || supervisoryCall;
  assign flag_d = flagClear         ? `SPS_REG_RST :
                  interruptReturn   ? popFlagData :
                  supervisoryReturn ? savedFlag_q :
                  flagWrite         ? flagWriteData :
                  wrFlag            ? hwdata[`SPS_BYTE_MSB:0] :
                  flag_q;

  // Flag, its push copy and the supervisory save slot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q      <= `SPS_REG_RST;
      savedFlag_q <= `SPS_REG_RST;
      pushFlag_q  <= `SPS_REG_RST;
      pushValid_q <= 1'b0;
    end else begin
      flag_q      <= flag_d;
      pushValid_q <= interruptEntry;
      if (interruptEntry) begin
        pushFlag_q <= flag_q;
      end
      if (supervisoryCall) begin
        savedFlag_q <= flag_q;
      end
    end
  end

  assign flagValue     = flag_q;
  assign pushFlagData  = pushFlag_q;
  assign pushFlagValid = pushValid_q;

  // ****************************************************************
  // Page selection
  // ****************************************************************

  // Page pointers of other blocks are stored by them; they must be put
  // back by the service routine, this block never restores them
  wire logic [PAGE_W-1:0] page;
  wire logic [1:0]        pageMode;
  assign pageMode = flag_q[`SPS_MODE_HI:`SPS_MODE_LO];

  page_mux #(
    .PAGE_W (PAGE_W)
  ) u_page_mux (
    .pageMode      (pageMode),
    .accessKind    (accessKind),
    .regSpace      (regSpaceAccess),
    .curPage       (curPage_q),
    .stackPage     (stackPagePointer[PAGE_W-1:0]),
    .indexPage     (indexPagePointer[PAGE_W-1:0]),
    .moveReadPage  (moveReadPagePointer[PAGE_W-1:0]),
    .moveWritePage (moveWritePagePointer[PAGE_W-1:0]),
    .page          (page)
  );

  // Answer registered one cycle after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pageValid_q <= 1'b0;
      sramPage_q  <= '0;
      regSpace_q  <= 1'b0;
    end else begin
      pageValid_q <= accessValid;
      regSpace_q  <= accessValid && regSpaceAccess;
      if (accessValid) begin
        sramPage_q <= page;
      end
    end
  end

  assign pageValid   = pageValid_q;
  assign sramPage    = sramPage_q;
  assign regSpaceOut = regSpace_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  wire logic normalReq;
  wire logic idxReq;
  assign normalReq = accessValid && !regSpaceAccess &&
                     (accessKind == NORMAL_ACCESS || accessKind == MOVE_POINTER_ACCESS);
  assign idxReq    = accessValid && !regSpaceAccess && (accessKind == INDEXED_ACCESS);

  property p_normal_current;
    @(posedge clk) disable iff (!arst_n)
    normalReq && flag_q[`SPS_MODE_HI]
    |=> pageValid && (sramPage == $past(curPage_q));
  endproperty
  a_normal_current: assert property (p_normal_current)
    else $error("normal access missed current page");

  property p_normal_zero;
    @(posedge clk) disable iff (!arst_n)
    normalReq && !flag_q[`SPS_MODE_HI] |=> (sramPage == '0);
  endproperty
  a_normal_zero: assert property (p_normal_zero)
    else $error("normal access not on page 0");

  property p_entry_push_clear;
    @(posedge clk) disable iff (!arst_n)
    interruptEntry
    |=> (flagValue == '0) && pushFlagValid && (pushFlagData == $past(flag_q));
  endproperty
  a_entry_push_clear: assert property (p_entry_push_clear)
    else $error("interrupt entry did not push and clear flag");

  property p_return_restore;
    @(posedge clk) disable iff (!arst_n)
    interruptReturn && !flagClear |=> (flagValue == $past(popFlagData));
  endproperty
  a_return_restore: assert property (p_return_restore)
    else $error("interrupt return did not restore flag");

  property p_idx_stack;
    @(posedge clk) disable iff (!arst_n)
    idxReq && pageMode[0]
    |=> (sramPage == $past(stackPagePointer[PAGE_W-1:0]));
  endproperty
  a_idx_stack: assert property (p_idx_stack)
    else $error("indexed access missed stack page");

  property p_idx_index;
    @(posedge clk) disable iff (!arst_n)
    idxReq && (pageMode == 2'b10)
    |=> (sramPage == $past(indexPagePointer[PAGE_W-1:0]));
  endproperty
  a_idx_index: assert property (p_idx_index)
    else $error("indexed access missed index page");

  property p_idx_zero;
    @(posedge clk) disable iff (!arst_n)
    idxReq && (pageMode == 2'b00) |=> (sramPage == '0);
  endproperty
  a_idx_zero: assert property (p_idx_zero)
    else $error("indexed access in mode 00b not on page 0");

  property p_reg_space;
    @(posedge clk) disable iff (!arst_n)
    accessValid && regSpaceAccess && (accessKind == INDEXED_ACCESS)
    |=> regSpaceOut && (sramPage == '0);
  endproperty
  a_reg_space: assert property (p_reg_space)
    else $error("register space access was remapped");

  property p_stack_page;
    @(posedge clk) disable iff (!arst_n)
    accessValid && (accessKind == STACK_ACCESS)
    |=> (sramPage == $past(stackPagePointer[PAGE_W-1:0]));
  endproperty
  a_stack_page: assert property (p_stack_page)
    else $error("stack access missed stack page");

  property p_move_read;
    @(posedge clk) disable iff (!arst_n)
    accessValid && (accessKind == MOVE_READ_ACCESS)
    |=> (sramPage == $past(moveReadPagePointer[PAGE_W-1:0]));
  endproperty
  a_move_read: assert property (p_move_read)
    else $error("move read missed its page");

  property p_super_round;
    @(posedge clk) disable iff (!arst_n)
    supervisoryCall ##1 (supervisoryReturn && !flagClear && !interruptReturn)
    |=> (flagValue == $past(flag_q, 2));
  endproperty
  a_super_round: assert property (p_super_round)
    else $error("supervisory call did not restore flag");

  property p_cur_write;
    @(posedge clk) disable iff (!arst_n)
    wrCur |=> (curPage_q == $past(hwdata[PAGE_W-1:0])) && (hrdata[31:8] == '0);
  endproperty
  a_cur_write: assert property (p_cur_write)
    else $error("current page pointer write lost");

  property p_scratch_write;
    @(posedge clk) disable iff (!arst_n)
    wrScratch |=> (scratch_q[$past(wrSel)] == $past(hwdata[7:0]));
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch write lost");

  c_isr_round: cover property (@(posedge clk) disable iff (!arst_n)
    interruptEntry ##[1:20] interruptReturn);
  c_idx_index: cover property (@(posedge clk) disable iff (!arst_n)
    idxReq && (pageMode == 2'b10));
  c_scratch_wr: cover property (@(posedge clk) disable iff (!arst_n) wrScratch);
  c_cur_steer: cover property (@(posedge clk) disable iff (!arst_n)
    normalReq && flag_q[`SPS_MODE_HI] && (curPage_q != '0));

endmodule

// ### sim/core_model.sv
// Far-side model of the core: a byte stack for the pushed flag value.
// Assumes the page block pulses pushFlagValid once per interrupt entry.
module core_model
  import sram_page_select_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] pushFlagData,
  input  wire logic       pushFlagValid,
  input  wire logic       interruptReturn,
  output logic      [7:0] popFlagData
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] stackMem [8];
  int         depth;
  logic [7:0] lastPop;

  // ****************************************************************
  // Flag stack
  // ****************************************************************
  // Push on the block's pulse, pop on the return instruction
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      depth <= 0;
      lastPop <= 8'h00;
    end else if (pushFlagValid && depth < 8) begin
      stackMem[depth] <= pushFlagData;
      depth <= depth + 1;
    end else if (interruptReturn && depth > 0) begin
      lastPop <= stackMem[depth-1];
      depth <= depth - 1;
    end
  end

  // An empty stack shows a changed byte, so a stale value never passes
  always_comb begin
    popFlagData = (depth > 0) ? stackMem[depth-1] : ~lastPop;
  end
endmodule

// ### sim/test_sram_page_select.sv
// Self-checking bench for the SRAM page select block.
// Assumes one AHB-Lite master (this bench) and the core stack model.
module test_sram_page_select
  import sram_page_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, arst_n, hsel, hwrite, accessValid, regSpaceAccess, flagWrite;
  logic interruptEntry, interruptReturn, supervisoryCall, supervisoryReturn;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  stackPagePointer, indexPagePointer, moveReadPagePointer;
  logic [7:0]  moveWritePagePointer, flagWriteData;
  access_kind_type accessKind;
  wire logic        hready, hreadyout, hresp, pushFlagValid, pageValid, regSpaceOut;
  wire logic [31:0] hrdata;
  wire logic [7:0]  popFlagData, flagValue, pushFlagData;
  wire logic [0:0]  sramPage;
  int error_cnt, checks, cyc;
  logic [4:0] ptr; // {cur, stack, index, moveRead, moveWrite}

  assign hready = hreadyout;

  sram_page_select #(.PAGE_W(1)) i_sram_page_select (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .accessValid(accessValid), .accessKind(accessKind), .regSpaceAccess(regSpaceAccess),
    .stackPagePointer(stackPagePointer), .indexPagePointer(indexPagePointer),
    .moveReadPagePointer(moveReadPagePointer), .moveWritePagePointer(moveWritePagePointer),
    .flagWrite(flagWrite), .flagWriteData(flagWriteData), .interruptEntry(interruptEntry),
    .interruptReturn(interruptReturn), .popFlagData(popFlagData),
    .supervisoryCall(supervisoryCall), .supervisoryReturn(supervisoryReturn),
    .flagValue(flagValue), .pushFlagData(pushFlagData), .pushFlagValid(pushFlagValid),
    .pageValid(pageValid), .sramPage(sramPage), .regSpaceOut(regSpaceOut));

  core_model i_core_model (
    .clk(clk), .arst_n(arst_n), .pushFlagData(pushFlagData),
    .pushFlagValid(pushFlagValid), .interruptReturn(interruptReturn),
    .popFlagData(popFlagData));

  // ****************************************************************
  // Clock, timeout and report
  // ****************************************************************
  always #20 clk = ~clk;

  // Whole run is well under a thousand cycles; a hang stops here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ****************************************************************
  // Bus and core access tasks
  // ****************************************************************
  // Holds each phase until hready is sampled high; only the timeout ends a hang
  task automatic ahbXfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w; hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahbXfer(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahbXfer(1'b0, a, 32'h0, x);
    chk("hrdata", x, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // One page request; the answer is looked at in its single valid cycle
  task automatic acc(input access_kind_type k, input logic rs, input logic exp);
    @(posedge clk);
    accessValid <= 1'b1; accessKind <= k; regSpaceAccess <= rs;
    @(posedge clk);
    accessValid <= 1'b0;
    @(negedge clk);
    chk("pageValid", {31'h0, pageValid}, 32'h1);
    chk("sramPage", {31'h0, sramPage}, {31'h0, exp});
    chk("regSpaceOut", {31'h0, regSpaceOut}, {31'h0, rs});
  endtask

  // 0 flag write, 1 entry, 2 return, 3 supervisory call, 4 supervisory return
  task automatic pulse(input int which, input logic [7:0] d);
    @(posedge clk);
    case (which)
      0: begin flagWrite <= 1'b1; flagWriteData <= d; end
      1: interruptEntry <= 1'b1;
      2: interruptReturn <= 1'b1;
      3: supervisoryCall <= 1'b1;
      default: supervisoryReturn <= 1'b1;
    endcase
    @(posedge clk);
    flagWrite <= 1'b0; interruptEntry <= 1'b0; interruptReturn <= 1'b0;
    supervisoryCall <= 1'b0; supervisoryReturn <= 1'b0;
    @(negedge clk);
  endtask

  // Upper pointer bits are junk on purpose: only bit 0 may count
  task automatic setPtr(input logic [4:0] p);
    @(posedge clk);
    stackPagePointer <= {7'h2a, p[3]}; indexPagePointer <= {7'h55, p[2]};
    moveReadPagePointer <= {7'h33, p[1]}; moveWritePagePointer <= {7'h4c, p[0]};
    wr(32'h340, {31'h0, p[4]});
  endtask

  function automatic logic expPage(input logic [1:0] m, input access_kind_type k,
                                   input logic rs, input logic [4:0] p);
    case (k)
      STACK_ACCESS:      return p[3];
      MOVE_READ_ACCESS:  return p[1];
      MOVE_WRITE_ACCESS: return p[0];
      INDEXED_ACCESS:    return rs ? 1'b0 : (m == 2'b10) ? p[2] : m[0] ? p[3] : 1'b0;
      default:           return m[1] ? p[4] : 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    clk = 0; arst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; accessValid = 0; accessKind = NORMAL_ACCESS; regSpaceAccess = 0;
    stackPagePointer = 0; indexPagePointer = 0; moveReadPagePointer = 0;
    moveWritePagePointer = 0; flagWrite = 0; flagWriteData = 0; interruptEntry = 0;
    interruptReturn = 0; supervisoryCall = 0; supervisoryReturn = 0;
    error_cnt = 0; checks = 0; cyc = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset state and register access
    @(negedge clk);
    chk("flagValue", {24'h0, flagValue}, 32'h0);
    rdc(32'h340, 32'h0);
    for (int i = 0; i < 4; i++) rdc(32'h180 + 4 * i, 32'h0);
    wr(32'h340, 32'h1);
    rdc(32'h340, 32'h1);
    for (int i = 0; i < 4; i++) wr(32'h180 + 4 * i, 32'ha5 + i);
    for (int i = 0; i < 4; i++) rdc(32'h180 + 4 * i, 32'ha5 + i);
    rdc(32'h344, 32'h0);
    // Every mode and access kind under two opposite pointer sets
    for (int p = 0; p < 2; p++) begin
      ptr = p ? 5'b01010 : 5'b10101;
      setPtr(ptr);
      for (int m = 0; m < 4; m++) begin
        pulse(0, {m[1:0], 6'h00});
        for (int k = 0; k < 6; k++)
          acc(access_kind_type'(k), 1'b0, expPage(m[1:0], access_kind_type'(k), 1'b0, ptr));
        acc(INDEXED_ACCESS, 1'b1, 1'b0);
      end
    end
    // Interrupt entry and return around a mode and pointer change
    setPtr(5'b10101);
    pulse(0, 8'hc0);
    pulse(1, 8'h00);
    chk("pushFlagValid", {31'h0, pushFlagValid}, 32'h1);
    chk("pushFlagData", {24'h0, pushFlagData}, 32'hc0);
    chk("flagValue", {24'h0, flagValue}, 32'h0);
    acc(NORMAL_ACCESS, 1'b0, 1'b0);
    acc(INDEXED_ACCESS, 1'b0, 1'b0);
    pulse(0, 8'h80);
    wr(32'h340, 32'h0);
    acc(NORMAL_ACCESS, 1'b0, 1'b0);
    wr(32'h340, 32'h1);
    pulse(2, 8'h00);
    chk("flagValue", {24'h0, flagValue}, 32'hc0);
    acc(NORMAL_ACCESS, 1'b0, 1'b1);
    // Supervisory call runs in mode 00b, then the mode comes back
    pulse(3, 8'h00);
    chk("flagValue", {24'h0, flagValue}, 32'h0);
    acc(NORMAL_ACCESS, 1'b0, 1'b0);
    acc(MOVE_WRITE_ACCESS, 1'b0, 1'b1);
    pulse(4, 8'h00);
    chk("flagValue", {24'h0, flagValue}, 32'hc0);
    wr(32'h3dc, 32'h80);
    rdc(32'h3dc, 32'h80);
    // Call and return on adjacent cycles bring the mode straight back
    @(posedge clk);
    supervisoryCall <= 1'b1;
    @(posedge clk);
    supervisoryCall <= 1'b0;
    supervisoryReturn <= 1'b1;
    @(posedge clk);
    supervisoryReturn <= 1'b0;
    @(negedge clk);
    chk("flagValue", {24'h0, flagValue}, 32'h80);
    // Reset in mid-run clears the flag and the first scratch word again
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("flagValue", {24'h0, flagValue}, 32'h0);
    rdc(32'h180, 32'h0);
    test_done();
  end
endmodule
